/* src/rds_diameter_select.sv */
// Reel diameter source selection, diameter parameters and preset loading
`timescale 1ns/100ps
`include "rds_defines.svh"

module rds_diameter_select #(
  parameter int ANALOG_W = `RDS_ANALOG_W
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PAR_WR,
  input wire logic PAR_RD,
  input wire logic [15:0] PAR_ADDR,
  input wire logic [15:0] PAR_WDATA,
  output rds_pkg::rds_word_t PAR_RDATA,
  output logic PAR_ACK,
  output logic PAR_NAK,
  input wire logic DRIVE_STOPPED,
  input wire logic TENSION_MODE,
  input wire logic PRESET_LOAD,
  input wire logic PRESET_SEL_A,
  input wire logic PRESET_SEL_B,
  input wire logic [ANALOG_W:0] ANALOG_INPUTS,
  input wire logic [15:0] CALC_DIAM,
  input wire logic CALC_VALID,
  output logic [5:0] METHOD_ONEHOT,
  output logic USE_ENCODER_CARD,
  output logic USE_PULSE_TERMINALS,
  output logic USE_MOTOR_ENCODER,
  output rds_pkg::rds_word_t DIAM_FULL_SCALE,
  output rds_pkg::rds_word_t DIAM_EMPTY_REEL,
  output rds_pkg::rds_word_t REEL_PULSES_PER_TURN,
  output rds_pkg::rds_word_t TURNS_PER_LAYER,
  output rds_pkg::rds_word_t MATERIAL_THICKNESS,
  output rds_pkg::rds_word_t CURRENT_DIAMETER,
  output logic PRESET_LOADED
);

  // ----------------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------------
  localparam rds_pkg::rds_state_t RST_STATE = '{
    method: `RDS_RST_METHOD,
    full: `RDS_RST_FULL,
    empty: `RDS_RST_EMPTY,
    origin: `RDS_RST_ORIGIN,
    pre_a: `RDS_RST_PRESET,
    pre_b: `RDS_RST_PRESET,
    pre_c: `RDS_RST_PRESET,
    ppt: `RDS_RST_PPT,
    tpl: `RDS_RST_TPL,
    thick: `RDS_RST_THICK,
    cur: `RDS_RST_CUR,
    rdata: 16'h0000,
    ack: 1'b0,
    nak: 1'b0,
    load_prev: 1'b0,
    loaded: 1'b0,
    onehot: 6'h01,
    use_card: 1'b0,
    use_term: 1'b0,
    use_motor: 1'b0
  };

  rds_pkg::rds_state_t s_q;
  rds_pkg::rds_state_t s_d;
  rds_pkg::rds_word_t ana_diam;
  rds_pkg::rds_reg_t sel;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic in_range(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  function automatic rds_pkg::rds_word_t clamp_diam(input logic [15:0] v);
    if (v < `RDS_DIAM_MIN) begin
      clamp_diam = `RDS_DIAM_MIN;
    end else if (v > `RDS_DIAM_MAX) begin
      clamp_diam = `RDS_DIAM_MAX;
    end else begin
      clamp_diam = v;
    end
  endfunction : clamp_diam

  function automatic rds_pkg::rds_reg_t decode(input logic [15:0] a);
    case (a)
      `RDS_ADDR_METHOD: decode = rds_pkg::RDS_R_METHOD;
      `RDS_ADDR_FULL: decode = rds_pkg::RDS_R_FULL;
      `RDS_ADDR_EMPTY: decode = rds_pkg::RDS_R_EMPTY;
      `RDS_ADDR_ORIGIN: decode = rds_pkg::RDS_R_ORIGIN;
      `RDS_ADDR_PRE_A: decode = rds_pkg::RDS_R_PRE_A;
      `RDS_ADDR_PRE_B: decode = rds_pkg::RDS_R_PRE_B;
      `RDS_ADDR_PRE_C: decode = rds_pkg::RDS_R_PRE_C;
      `RDS_ADDR_PPT: decode = rds_pkg::RDS_R_PPT;
      `RDS_ADDR_TPL: decode = rds_pkg::RDS_R_TPL;
      `RDS_ADDR_THICK: decode = rds_pkg::RDS_R_THICK;
      `RDS_ADDR_CUR: decode = rds_pkg::RDS_R_CUR;
      default: decode = rds_pkg::RDS_R_NONE;
    endcase
  endfunction : decode

  function automatic rds_pkg::rds_word_t read_word(
    input rds_pkg::rds_reg_t r,
    input rds_pkg::rds_state_t s
  );
    case (r)
      rds_pkg::RDS_R_METHOD: begin
        read_word = s.method;
      end
      rds_pkg::RDS_R_FULL: begin
        read_word = s.full;
      end
      rds_pkg::RDS_R_EMPTY: begin
        read_word = s.empty;
      end
      rds_pkg::RDS_R_ORIGIN: begin
        read_word = s.origin;
      end
      rds_pkg::RDS_R_PRE_A: begin
        read_word = s.pre_a;
      end
      rds_pkg::RDS_R_PRE_B: begin
        read_word = s.pre_b;
      end
      rds_pkg::RDS_R_PRE_C: begin
        read_word = s.pre_c;
      end
      rds_pkg::RDS_R_PPT: begin
        read_word = s.ppt;
      end
      rds_pkg::RDS_R_TPL: begin
        read_word = s.tpl;
      end
      rds_pkg::RDS_R_THICK: begin
        read_word = s.thick;
      end
      rds_pkg::RDS_R_CUR: begin
        read_word = s.cur;
      end
      default: read_word = 16'h0000;
    endcase
  endfunction : read_word

  // ----------------------------------------------------------------------
  // Analog diameter scaling
  // ----------------------------------------------------------------------
  rds_analog_scale #(
    .ANALOG_W(ANALOG_W)
  ) u_scale (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .code(ANALOG_INPUTS),
    .full_scale(s_q.full),
    .diam(ana_diam)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic ok;
    ok = 1'b0;
    sel = decode(PAR_ADDR);
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.nak = 1'b0;
    s_d.loaded = 1'b0;
    s_d.load_prev = PRESET_LOAD;

    // Current diameter follows the selected source
    if (s_q.method == `RDS_M_ANALOG) begin
      s_d.cur = clamp_diam(ana_diam);
    end else if (CALC_VALID && !DRIVE_STOPPED) begin
      s_d.cur = clamp_diam(CALC_DIAM);
    end

    // Analog origin overwrites preset A
    if (s_q.origin == `RDS_ORIGIN_ANALOG) begin
      s_d.pre_a = clamp_diam(ana_diam);
    end

    // Parameter access, whole 16-bit words only
    if (PAR_WR) begin
      case (sel)
        rds_pkg::RDS_R_METHOD: begin
          ok = in_range(PAR_WDATA, 16'h0000, `RDS_METHOD_MAX);
          if (ok) begin
            s_d.method = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_FULL: begin
          ok = in_range(PAR_WDATA, `RDS_DIAM_MIN, `RDS_DIAM_MAX);
          if (ok) begin
            s_d.full = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_EMPTY: begin
          ok = in_range(PAR_WDATA, `RDS_DIAM_MIN, `RDS_DIAM_MAX);
          if (ok) begin
            s_d.empty = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_ORIGIN: begin
          ok = in_range(PAR_WDATA, 16'h0000, `RDS_ORIGIN_MAX);
          if (ok) begin
            s_d.origin = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_PRE_A: begin
          ok = (s_q.origin != `RDS_ORIGIN_ANALOG) &&
               in_range(PAR_WDATA, `RDS_DIAM_MIN, `RDS_DIAM_MAX);
          if (ok) begin
            s_d.pre_a = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_PRE_B: begin
          ok = in_range(PAR_WDATA, `RDS_DIAM_MIN, `RDS_DIAM_MAX);
          if (ok) begin
            s_d.pre_b = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_PRE_C: begin
          ok = in_range(PAR_WDATA, `RDS_DIAM_MIN, `RDS_DIAM_MAX);
          if (ok) begin
            s_d.pre_c = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_PPT: begin
          ok = in_range(PAR_WDATA, `RDS_PPT_MIN, `RDS_PPT_MAX);
          if (ok) begin
            s_d.ppt = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_TPL: begin
          ok = in_range(PAR_WDATA, `RDS_TPL_MIN, `RDS_TPL_MAX);
          if (ok) begin
            s_d.tpl = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_THICK: begin
          ok = in_range(PAR_WDATA, `RDS_THICK_MIN, `RDS_THICK_MAX);
          if (ok) begin
            s_d.thick = PAR_WDATA;
          end
        end
        rds_pkg::RDS_R_CUR: begin
          ok = DRIVE_STOPPED &&
               in_range(PAR_WDATA, `RDS_DIAM_MIN, `RDS_DIAM_MAX);
          if (ok) begin
            s_d.cur = PAR_WDATA;
          end
        end
        default: begin
          ok = 1'b0;
        end
      endcase
      s_d.ack = ok;
      s_d.nak = !ok;
    end else if (PAR_RD) begin
      s_d.rdata = read_word(sel, s_q);
      s_d.ack = (sel != rds_pkg::RDS_R_NONE);
      s_d.nak = (sel == rds_pkg::RDS_R_NONE);
    end

    // Preset loading on the rising edge of the load function
    if (PRESET_LOAD && !s_q.load_prev && DRIVE_STOPPED &&
        TENSION_MODE) begin
      case ({PRESET_SEL_B, PRESET_SEL_A})
        2'b00: begin
          s_d.cur = s_q.pre_a;
        end
        2'b01: begin
          s_d.cur = s_q.pre_b;
        end
        2'b10: begin
          s_d.cur = s_q.pre_c;
        end
        default: begin
          s_d.cur = `RDS_RST_CUR;
        end
      endcase
      s_d.loaded = 1'b1;
    end

    // Source routing decoded from the method field
    s_d.onehot = 6'h01 << s_d.method[2:0];
    s_d.use_card = (s_d.method == `RDS_M_REEL_CARD) ||
                   (s_d.method == `RDS_M_MOTOR_CARD);
    s_d.use_term = (s_d.method == `RDS_M_REEL_TERM) ||
                   (s_d.method == `RDS_M_MOTOR_TERM);
    s_d.use_motor = (s_d.method == `RDS_M_MOTOR_CARD) ||
                    (s_d.method == `RDS_M_MOTOR_TERM);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      s_q <= RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign PAR_RDATA = s_q.rdata;
  assign PAR_ACK = s_q.ack;
  assign PAR_NAK = s_q.nak;
  assign METHOD_ONEHOT = s_q.onehot;
  assign USE_ENCODER_CARD = s_q.use_card;
  assign USE_PULSE_TERMINALS = s_q.use_term;
  assign USE_MOTOR_ENCODER = s_q.use_motor;
  assign DIAM_FULL_SCALE = s_q.full;
  assign DIAM_EMPTY_REEL = s_q.empty;
  assign REEL_PULSES_PER_TURN = s_q.ppt;
  assign TURNS_PER_LAYER = s_q.tpl;
  assign MATERIAL_THICKNESS = s_q.thick;
  assign CURRENT_DIAMETER = s_q.cur;
  assign PRESET_LOADED = s_q.loaded;

endmodule : rds_diameter_select

/* src/rds_defines.svh */
// Offsets, reset values, ranges and codes of the reel diameter parameters
`ifndef RDS_DEFINES_SVH
`define RDS_DEFINES_SVH

// ----------------------------------------------------------------------
// Parameter addresses
// ----------------------------------------------------------------------
`define RDS_ADDR_METHOD 16'h0C1B
`define RDS_ADDR_FULL 16'h0C1C
`define RDS_ADDR_EMPTY 16'h0C1D
`define RDS_ADDR_ORIGIN 16'h0C1E
`define RDS_ADDR_PRE_A 16'h0C1F
`define RDS_ADDR_PRE_B 16'h0C20
`define RDS_ADDR_PRE_C 16'h0C21
`define RDS_ADDR_PPT 16'h0C22
`define RDS_ADDR_TPL 16'h0C23
`define RDS_ADDR_THICK 16'h0C24
`define RDS_ADDR_CUR 16'h0C28

// ----------------------------------------------------------------------
// Reset values, diameters in tenths of a millimetre
// ----------------------------------------------------------------------
`define RDS_RST_METHOD 16'h0000
`define RDS_RST_FULL 16'hEA60
`define RDS_RST_EMPTY 16'h000A
`define RDS_RST_ORIGIN 16'h0000
`define RDS_RST_PRESET 16'h000A
`define RDS_RST_PPT 16'h0001
`define RDS_RST_TPL 16'h0001
`define RDS_RST_THICK 16'h0001
`define RDS_RST_CUR 16'h000A

// ----------------------------------------------------------------------
// Accepted ranges
// ----------------------------------------------------------------------
`define RDS_DIAM_MIN 16'h000A
`define RDS_DIAM_MAX 16'hEA60
`define RDS_PPT_MIN 16'h0001
`define RDS_PPT_MAX 16'hEA60
`define RDS_TPL_MIN 16'h0001
`define RDS_TPL_MAX 16'h2710
`define RDS_THICK_MIN 16'h0001
`define RDS_THICK_MAX 16'hFDE8
`define RDS_METHOD_MAX 16'h0005
`define RDS_ORIGIN_MAX 16'h0001

// ----------------------------------------------------------------------
// Method and origin codes
// ----------------------------------------------------------------------
`define RDS_M_LINE 16'h0000
`define RDS_M_ANALOG 16'h0001
`define RDS_M_REEL_CARD 16'h0002
`define RDS_M_MOTOR_CARD 16'h0003
`define RDS_M_REEL_TERM 16'h0004
`define RDS_M_MOTOR_TERM 16'h0005
`define RDS_ORIGIN_ANALOG 16'h0001

// Analog code width; full code 2**W stands for 10 V
`define RDS_ANALOG_W 12

`endif

/* src/rds_pkg.sv */
// Types shared by the reel diameter source select block
package rds_pkg;

  typedef logic [15:0] rds_word_t;

  // ----------------------------------------------------------------------
  // Parameter selected by an address
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    RDS_R_METHOD,
    RDS_R_FULL,
    RDS_R_EMPTY,
    RDS_R_ORIGIN,
    RDS_R_PRE_A,
    RDS_R_PRE_B,
    RDS_R_PRE_C,
    RDS_R_PPT,
    RDS_R_TPL,
    RDS_R_THICK,
    RDS_R_CUR,
    RDS_R_NONE
  } rds_reg_t;

  // ----------------------------------------------------------------------
  // Whole state of the top module
  // ----------------------------------------------------------------------
  typedef struct packed {
    rds_word_t method;
    rds_word_t full;
    rds_word_t empty;
    rds_word_t origin;
    rds_word_t pre_a;
    rds_word_t pre_b;
    rds_word_t pre_c;
    rds_word_t ppt;
    rds_word_t tpl;
    rds_word_t thick;
    rds_word_t cur;
    rds_word_t rdata;
    logic ack;
    logic nak;
    logic load_prev;
    logic loaded;
    logic [5:0] onehot;
    logic use_card;
    logic use_term;
    logic use_motor;
  } rds_state_t;

endpackage : rds_pkg

/* src/rds_analog_scale.sv */
// Scales an analog code to a diameter against the full-scale diameter
`timescale 1ns/100ps
`include "rds_defines.svh"

module rds_analog_scale #(
  parameter int ANALOG_W = `RDS_ANALOG_W
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ANALOG_W:0] code,
  input wire rds_pkg::rds_word_t full_scale,
  output rds_pkg::rds_word_t diam
);

  typedef struct packed {
    rds_pkg::rds_word_t diam;
  } rds_scale_state_t;

  localparam logic [ANALOG_W:0] FULL_CODE = {1'b1, {ANALOG_W{1'b0}}};

  rds_scale_state_t s_q;
  rds_scale_state_t s_d;
  logic [ANALOG_W:0] code_lim;
  logic [ANALOG_W+16:0] product;

  // ----------------------------------------------------------------------
  // Full code equals full-scale diameter
  // ----------------------------------------------------------------------
  always_comb begin
    code_lim = (code > FULL_CODE) ? FULL_CODE : code;
    product = code_lim * full_scale;
    s_d.diam = product[ANALOG_W +: 16];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '{diam: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign diam = s_q.diam;

endmodule : rds_analog_scale

/* test/rds_sel_assertions.sv */
// Checker on the ports of the reel diameter source select block
`timescale 1ns/100ps
`include "rds_defines.svh"

module rds_sel_assertions (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic PAR_WR,
  input wire logic PAR_RD,
  input wire logic [15:0] PAR_ADDR,
  input wire logic [15:0] PAR_WDATA,
  input wire logic PAR_ACK,
  input wire logic PAR_NAK,
  input wire logic DRIVE_STOPPED,
  input wire logic TENSION_MODE,
  input wire logic PRESET_LOAD,
  input wire logic PRESET_SEL_A,
  input wire logic PRESET_SEL_B,
  input wire logic [5:0] METHOD_ONEHOT,
  input wire logic USE_ENCODER_CARD,
  input wire logic USE_PULSE_TERMINALS,
  input wire logic USE_MOTOR_ENCODER,
  input wire rds_pkg::rds_word_t CURRENT_DIAMETER,
  input wire logic PRESET_LOADED
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence load_rise;
    $rose(PRESET_LOAD) && DRIVE_STOPPED && TENSION_MODE;
  endsequence

  sequence bad_method;
    PAR_WR && PAR_ADDR == `RDS_ADDR_METHOD && PAR_WDATA > `RDS_METHOD_MAX;
  endsequence

  req_answer_a: assert property ((PAR_WR || PAR_RD) |=> PAR_ACK != PAR_NAK)
    else $error("request not answered once");
  idle_quiet_a: assert property (!(PAR_WR || PAR_RD) |=> !PAR_ACK && !PAR_NAK)
    else $error("answer without request");
  method_onehot_a: assert property ($onehot(METHOD_ONEHOT))
    else $error("method select not one-hot");
  card_route_a: assert property (USE_ENCODER_CARD ==
    (METHOD_ONEHOT[2] || METHOD_ONEHOT[3])) else $error("card route wrong");
  term_route_a: assert property (USE_PULSE_TERMINALS ==
    (METHOD_ONEHOT[4] || METHOD_ONEHOT[5])) else $error("terminal route wrong");
  motor_route_a: assert property (USE_MOTOR_ENCODER ==
    (METHOD_ONEHOT[3] || METHOD_ONEHOT[5])) else $error("motor route wrong");
  method_range_a: assert property (bad_method |=>
    PAR_NAK && $stable(METHOD_ONEHOT)) else $error("bad method taken");
  cur_locked_a: assert property (PAR_WR && PAR_ADDR == `RDS_ADDR_CUR
    && !DRIVE_STOPPED |=> PAR_NAK) else $error("running write taken");
  load_done_a: assert property (load_rise |=> PRESET_LOADED)
    else $error("preset load missed");
  load_gate_a: assert property (!($rose(PRESET_LOAD) && DRIVE_STOPPED
    && TENSION_MODE) |=> !PRESET_LOADED) else $error("stray preset load");
  default_load_a: assert property (load_rise ##0 (PRESET_SEL_A
    && PRESET_SEL_B) |=> CURRENT_DIAMETER == `RDS_RST_CUR)
    else $error("default load wrong");
endmodule : rds_sel_assertions

bind rds_diameter_select rds_sel_assertions chk (.*);

/* test/rds_host_model.sv */
// Host model that reads and writes the diameter parameters
`timescale 1ns/100ps
`include "rds_defines.svh"

module rds_host_model (
  input wire logic sys_clk,
  input wire logic par_ack,
  input wire rds_pkg::rds_word_t par_rdata,
  output logic par_wr,
  output logic par_rd,
  output logic [15:0] par_addr,
  output logic [15:0] par_wdata
);
  initial begin
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_addr = 16'h0000;
    par_wdata = 16'h0000;
  end

  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output logic ok, output rds_pkg::rds_word_t q);
    @(posedge sys_clk);
    par_wr <= w;
    par_rd <= !w;
    par_addr <= a;
    par_wdata <= d;
    @(posedge sys_clk);
    par_wr <= 1'b0;
    par_rd <= 1'b0;
    par_addr <= ~a;
    par_wdata <= ~d;
    @(posedge sys_clk);
    ok = par_ack;
    q = par_rdata;
  endtask : xfer

  task automatic cfg_method(input logic [15:0] m, output logic ok);
    rds_pkg::rds_word_t q;
    // Reel pulse count set before a reel encoder method
    if (m == `RDS_M_REEL_CARD || m == `RDS_M_REEL_TERM)
      xfer(1'b1, `RDS_ADDR_PPT, 16'h0400, ok, q);
    // Encoder card assumed fitted for methods 2 and 3
    // Pulse kind and winding mode kept outside for method 5
    xfer(1'b1, `RDS_ADDR_METHOD, m, ok, q);
  endtask : cfg_method
endmodule : rds_host_model

/* test/tb_top.sv */
// Testbench of the reel diameter source select block
`timescale 1ns/100ps
`include "rds_defines.svh"

module tb_top;
  logic SYS_CLK, RESET_N, PAR_WR, PAR_RD, PAR_ACK, PAR_NAK;
  logic DRIVE_STOPPED, TENSION_MODE, PRESET_LOAD, PRESET_LOADED;
  logic PRESET_SEL_A, PRESET_SEL_B, CALC_VALID;
  logic USE_ENCODER_CARD, USE_PULSE_TERMINALS, USE_MOTOR_ENCODER;
  logic [12:0] ANALOG_INPUTS;
  logic [15:0] CALC_DIAM, PAR_ADDR, PAR_WDATA;
  logic [5:0] METHOD_ONEHOT;
  rds_pkg::rds_word_t PAR_RDATA, DIAM_FULL_SCALE, DIAM_EMPTY_REEL;
  rds_pkg::rds_word_t REEL_PULSES_PER_TURN, TURNS_PER_LAYER;
  rds_pkg::rds_word_t MATERIAL_THICKNESS, CURRENT_DIAMETER;
  int n_mismatch = 0;
  int num_checks = 0;

  rds_diameter_select uut (.*);
  rds_host_model host (
    .sys_clk(SYS_CLK),
    .par_ack(PAR_ACK),
    .par_rdata(PAR_RDATA),
    .par_wr(PAR_WR),
    .par_rd(PAR_RD),
    .par_addr(PAR_ADDR),
    .par_wdata(PAR_WDATA)
  );

  // ----------------------------------------------------------------------
  // Compare and access tasks
  // ----------------------------------------------------------------------
  task automatic chk_w(input rds_pkg::rds_word_t g, e, input string s);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk_w

  task automatic chk_b(input logic g, e, input string s);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %b exp %b", $time, s, g, e);
    end
  endtask : chk_b

  task automatic wr(input logic [15:0] a, d, input logic e);
    logic ok;
    rds_pkg::rds_word_t q;
    host.xfer(1'b1, a, d, ok, q);
    chk_b(ok, e, "write answer");
    chk_b(PAR_NAK, !e, "write refusal");
  endtask : wr

  task automatic rd(input logic [15:0] a, e, input logic k);
    logic ok;
    rds_pkg::rds_word_t q;
    host.xfer(1'b0, a, 16'h0000, ok, q);
    chk_b(ok, k, "read answer");
    chk_b(PAR_NAK, !k, "read refusal");
    chk_w(q, e, "read data");
  endtask : rd

  task automatic load(input logic [1:0] s, input logic [15:0] e,
                      input logic k);
    @(posedge SYS_CLK);
    PRESET_LOAD <= 1'b1;
    {PRESET_SEL_B, PRESET_SEL_A} <= s;
    repeat (2) @(posedge SYS_CLK);
    chk_w(CURRENT_DIAMETER, e, "current after load");
    chk_b(PRESET_LOADED, k, "load pulse");
    PRESET_LOAD <= 1'b0;
    @(posedge SYS_CLK);
    chk_b(PRESET_LOADED, 1'b0, "load pulse end");
  endtask : load

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_vals();
    logic [15:0] ad [11] = '{`RDS_ADDR_METHOD, `RDS_ADDR_FULL,
      `RDS_ADDR_EMPTY, `RDS_ADDR_ORIGIN, `RDS_ADDR_PRE_A, `RDS_ADDR_PRE_B,
      `RDS_ADDR_PRE_C, `RDS_ADDR_PPT, `RDS_ADDR_TPL, `RDS_ADDR_THICK,
      `RDS_ADDR_CUR};
    logic [15:0] rv [11] = '{16'h0000, 16'hEA60, 16'h000A, 16'h0000,
      16'h000A, 16'h000A, 16'h000A, 16'h0001, 16'h0001, 16'h0001, 16'h000A};
    for (int i = 0; i < 11; i++) begin
      rd(ad[i], rv[i], 1'b1);
    end
    rd(16'h0C25, 16'h0000, 1'b0);
    chk_w({10'h000, METHOD_ONEHOT}, 16'h0001, "onehot reset");
  endtask : t_reset_vals

  task automatic t_methods();
    logic ok;
    for (int m = 0; m < 6; m++) begin
      host.cfg_method(16'(m), ok);
      chk_b(ok, 1'b1, "method write");
      chk_w({10'h000, METHOD_ONEHOT}, 16'h0001 << m, "onehot");
      chk_b(USE_ENCODER_CARD, m == 2 || m == 3, "card");
      chk_b(USE_MOTOR_ENCODER, m == 3 || m == 5, "motor");
      chk_b(USE_PULSE_TERMINALS, m == 4 || m == 5, "terminals");
    end
    chk_w(REEL_PULSES_PER_TURN, 16'h0400, "pulses");
    wr(`RDS_ADDR_METHOD, 16'h0006, 1'b0);
    chk_w({10'h000, METHOD_ONEHOT}, 16'h0020, "onehot kept");
  endtask : t_methods

  task automatic t_ranges();
    wr(`RDS_ADDR_FULL, 16'h0009, 1'b0);
    wr(`RDS_ADDR_FULL, 16'h000A, 1'b1);
    wr(`RDS_ADDR_FULL, 16'hEA61, 1'b0);
    chk_w(DIAM_FULL_SCALE, 16'h000A, "full scale");
    wr(`RDS_ADDR_FULL, 16'hEA60, 1'b1);
    wr(`RDS_ADDR_EMPTY, 16'h0009, 1'b0);
    wr(`RDS_ADDR_EMPTY, 16'h0032, 1'b1);
    chk_w(DIAM_EMPTY_REEL, 16'h0032, "empty reel");
    wr(`RDS_ADDR_PPT, 16'hEA61, 1'b0);
    wr(`RDS_ADDR_TPL, 16'h2711, 1'b0);
    wr(`RDS_ADDR_TPL, 16'h2710, 1'b1);
    chk_w(TURNS_PER_LAYER, 16'h2710, "turns");
    wr(`RDS_ADDR_THICK, 16'h0000, 1'b0);
    wr(`RDS_ADDR_THICK, 16'hFDE8, 1'b1);
    chk_w(MATERIAL_THICKNESS, 16'hFDE8, "thickness");
  endtask : t_ranges

  task automatic t_origin();
    wr(`RDS_ADDR_ORIGIN, 16'h0002, 1'b0);
    wr(`RDS_ADDR_ORIGIN, 16'h0001, 1'b1);
    wr(`RDS_ADDR_PRE_A, 16'h0064, 1'b0);
    rd(`RDS_ADDR_PRE_A, 16'hEA60, 1'b1);
    wr(`RDS_ADDR_ORIGIN, 16'h0000, 1'b1);
    wr(`RDS_ADDR_PRE_A, 16'h0064, 1'b1);
  endtask : t_origin

  task automatic t_analog();
    wr(`RDS_ADDR_METHOD, `RDS_M_ANALOG, 1'b1);
    ANALOG_INPUTS <= 13'h0800;
    repeat (3) @(posedge SYS_CLK);
    chk_w(CURRENT_DIAMETER, 16'h7530, "half scale");
    ANALOG_INPUTS <= 13'h1FFF;
    repeat (3) @(posedge SYS_CLK);
    chk_w(CURRENT_DIAMETER, 16'hEA60, "clamped");
    wr(`RDS_ADDR_METHOD, `RDS_M_LINE, 1'b1);
  endtask : t_analog

  task automatic t_load();
    wr(`RDS_ADDR_PRE_B, 16'h00C8, 1'b1);
    wr(`RDS_ADDR_PRE_C, 16'h012C, 1'b1);
    load(2'b00, 16'h0064, 1'b1);
    load(2'b01, 16'h00C8, 1'b1);
    load(2'b10, 16'h012C, 1'b1);
    load(2'b11, 16'h000A, 1'b1);
    TENSION_MODE <= 1'b0;
    load(2'b01, 16'h000A, 1'b0);
    TENSION_MODE <= 1'b1;
  endtask : t_load

  task automatic t_cur();
    wr(`RDS_ADDR_CUR, 16'h01F4, 1'b1);
    DRIVE_STOPPED <= 1'b0;
    wr(`RDS_ADDR_CUR, 16'h0258, 1'b0);
    chk_w(CURRENT_DIAMETER, 16'h01F4, "current kept");
    load(2'b01, 16'h01F4, 1'b0);
    CALC_DIAM <= 16'h02BC;
    CALC_VALID <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    chk_w(CURRENT_DIAMETER, 16'h02BC, "tracked");
    CALC_VALID <= 1'b0;
  endtask : t_cur

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    RESET_N = 1'b0;
    DRIVE_STOPPED = 1'b1;
    TENSION_MODE = 1'b1;
    PRESET_LOAD = 1'b0;
    PRESET_SEL_A = 1'b0;
    PRESET_SEL_B = 1'b0;
    CALC_VALID = 1'b0;
    CALC_DIAM = 16'h0000;
    ANALOG_INPUTS = 13'h1000;
    repeat (6) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    t_reset_vals();
    t_methods();
    t_ranges();
    t_origin();
    t_analog();
    t_load();
    t_cur();
    wrap_up();
  end
endmodule : tb_top
